// [rtl/csl_defs.svh]
// Purpose: offsets, field positions, reset values and timing counts of the state supervisor
// Assumes: apb byte addresses, 32-bit data, 250 MHz system clock
// Notes:   flash pattern lengths are counted in timebase ticks
`ifndef CSL_DEFS_SVH
`define CSL_DEFS_SVH

`define CSL_REG_CTRL        12'h000
`define CSL_REG_CMD         12'h004
`define CSL_REG_STATUS      12'h008
`define CSL_REG_FAULT_A     12'h00C
`define CSL_REG_FAULT_B     12'h010

`define CSL_CTRL_UPD        0
`define CSL_CTRL_DFLT       1
`define CSL_CTRL_RST        2'h1

`define CSL_CMD_RUN         0
`define CSL_CMD_STOP        1
`define CSL_CMD_RESET       2
`define CSL_CMD_DNLD        3

`define CSL_CLK_NS          4
`define CSL_TICK_NS         50000000
`define CSL_REG_ON          5'h04
`define CSL_REG_PER         5'h08
`define CSL_SGL_ON          5'h04
`define CSL_SGL_PER         5'h18
`define CSL_FAST_ON         5'h01
`define CSL_FAST_PER        5'h02

`endif

// [rtl/csl_pkg.sv]
// Purpose: types shared by the state supervisor and its bench
// Assumes: nothing beyond the defs header
// Notes:   state codes follow declaration order from 0; status shows them as a 3-bit value
package csl_pkg;
    typedef enum logic [2:0] {
        ST_EMPTY,
        ST_EMPTY_SYSERR,
        ST_RUNNING,
        ST_STOP_ENTRY,
        ST_STOPPED,
        ST_HALT
    } csl_state_type;
endpackage : csl_pkg

// [rtl/csl_top.sv]
// Purpose: controller state supervisor with led patterns, stop-state i/o and can master gating
// Assumes: all inputs synchronous to clk_sys; apb slave with one wait-free access phase
// Notes:   indicator, image and can controls are all registered
// Contract
// - no application: empty, run off, err single-flash
// - system error: empty, err fast-flash, reload clears
// - running: run on, err and io off
// - breakpoint: suspend tasks, run single-flash
// - external error or fault word: io on
// - stopped: run regular-flash, err io off
// - stopped with external error: io on
// - application error: halt, run flash, err on
// - boot copy differs: err single-flash
// - communication services stay active while stopped
// - stop entry applies stop behaviour plus forcing
// - update enabled: keep sampling inputs when stopped
// - stopped: task processing never runs
// - update enabled: keep writing forced stop image
// - update enabled: can master stays fully active
// - update enabled: tpdos carry last or defaults
// - update disabled: apply outputs, then freeze inputs
// - update disabled: physical outputs hold stop values
// - update disabled: can master traffic stops
// - tpdos loaded before stopping; sent once only with update disabled
// - halt left only by reset, download or system error
`timescale 1ns/1ps
`include "csl_defs.svh"

module csl_top #(
    parameter int          W        = 16,
    parameter int unsigned TICK_CYC = `CSL_TICK_NS / `CSL_CLK_NS
) (
    input  wire logic          clk_sys,
    input  wire logic          nrst,
    input  wire logic [11:0]   paddr,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [31:0]   pwdata,
    input  wire logic [3:0]    pstrb,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          app_present,
    input  wire logic          sys_error_evt,
    input  wire logic          app_error_evt,
    input  wire logic          ext_io_error,
    input  wire logic          breakpoint_active,
    input  wire logic          boot_differs,
    input  wire logic [31:0]   system_fault_word_a,
    input  wire logic [31:0]   system_fault_word_b,
    input  wire logic [W-1:0]  phys_in,
    input  wire logic [W-1:0]  out_img,
    input  wire logic [W-1:0]  out_dflt,
    input  wire logic [W-1:0]  force_mask,
    input  wire logic [W-1:0]  force_val,
    output logic      [W-1:0]  in_img,
    output logic      [W-1:0]  phys_out,
    output logic               led_run,
    output logic               led_err,
    output logic               led_io,
    output logic               task_en,
    output logic               can_active,
    output logic               tpdo_load,
    output logic               tpdo_dflt,
    output logic               tpdo_send
);

    csl_pkg::csl_state_type state_q;
    csl_pkg::csl_state_type state_d;

    logic [1:0]     ctrl_q;
    logic           boot_seen_q;
    logic [31:0]    prdata_q;
    logic           pready_q;
    logic           pslverr_q;
    logic [31:0]    tick_cnt_q;
    logic [4:0]     phase_q;
    logic [W-1:0]   in_img_q;
    logic [W-1:0]   phys_out_q;
    logic [W-1:0]   stop_val_q;
    logic           led_run_q;
    logic           led_err_q;
    logic           led_io_q;
    logic           task_en_q;
    logic           can_active_q;
    logic           tpdo_load_q;
    logic           tpdo_dflt_q;
    logic           tpdo_send_q;

    // apb decode; remote commands are served in every state
    wire            setup_w    = psel & ~penable;
    wire            wr_w       = psel & penable & pwrite & pready_q;
    wire            sel_ctrl   = paddr == `CSL_REG_CTRL;
    wire            sel_cmd    = paddr == `CSL_REG_CMD;
    wire            sel_stat   = paddr == `CSL_REG_STATUS;
    wire            sel_fa     = paddr == `CSL_REG_FAULT_A;
    wire            sel_fb     = paddr == `CSL_REG_FAULT_B;
    wire            mapped_w   = sel_ctrl | sel_cmd | sel_stat | sel_fa | sel_fb;
    wire            wr_ctrl_w  = wr_w & sel_ctrl & pstrb[0];
    wire            wr_cmd_w   = wr_w & sel_cmd & pstrb[0];
    wire            cmd_run    = wr_cmd_w & pwdata[`CSL_CMD_RUN];
    wire            cmd_stop   = wr_cmd_w & pwdata[`CSL_CMD_STOP];
    wire            cmd_reset  = wr_cmd_w & pwdata[`CSL_CMD_RESET];
    wire            cmd_dnld   = wr_cmd_w & pwdata[`CSL_CMD_DNLD];
    wire            upd_w      = ctrl_q[`CSL_CTRL_UPD];
    wire            dflt_w     = ctrl_q[`CSL_CTRL_DFLT];

    wire [31:0]     status_w   = {24'h00_0000, boot_differs, ext_io_error, led_io_q,
                                  led_err_q, led_run_q, 3'(state_q)};
    wire [31:0]     rd_mux_w   = sel_ctrl ? {30'h0000_0000, ctrl_q} :
                                 sel_stat ? status_w :
                                 sel_fa   ? system_fault_word_a :
                                 sel_fb   ? system_fault_word_b : 32'h0000_0000;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ctrl_q    <= `CSL_CTRL_RST;
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            if (wr_ctrl_w)
                ctrl_q <= pwdata[1:0];
            if (setup_w)
                prdata_q <= rd_mux_w;
            pready_q  <= setup_w;
            pslverr_q <= setup_w & ~mapped_w;
        end
    end

    // one prescaled tick feeds every flash pattern, so they stay in phase
    wire            tick_w     = tick_cnt_q == 32'(TICK_CYC - 1);
    wire            phase_end  = phase_q == `CSL_SGL_PER - 5'h01;
    wire            reg_fl     = (phase_q % `CSL_REG_PER) < `CSL_REG_ON;
    wire            sgl_fl     = phase_q < `CSL_SGL_ON;
    wire            fast_fl    = (phase_q % `CSL_FAST_PER) < `CSL_FAST_ON;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            tick_cnt_q <= 32'h0000_0000;
            phase_q    <= 5'h00;
        end else begin
            tick_cnt_q <= tick_w ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
            if (tick_w)
                phase_q <= phase_end ? 5'h00 : phase_q + 5'h01;
        end
    end

    // state sequencing; a system error outranks everything else
    always_comb begin
        state_d = state_q;
        case (state_q)
            csl_pkg::ST_EMPTY: begin
                // a present application is taken up once after power-on
                if ((app_present && !boot_seen_q) || cmd_dnld)
                    state_d = csl_pkg::ST_STOP_ENTRY;
            end
            csl_pkg::ST_EMPTY_SYSERR: begin
                if (cmd_dnld)
                    state_d = csl_pkg::ST_STOP_ENTRY;
            end
            csl_pkg::ST_RUNNING: begin
                if (app_error_evt)
                    state_d = csl_pkg::ST_HALT;
                else if (cmd_stop || cmd_dnld)
                    state_d = csl_pkg::ST_STOP_ENTRY;
            end
            csl_pkg::ST_STOP_ENTRY: begin
                state_d = csl_pkg::ST_STOPPED;
            end
            csl_pkg::ST_STOPPED: begin
                if (cmd_dnld)
                    state_d = csl_pkg::ST_STOP_ENTRY;
                else if (cmd_run)
                    state_d = csl_pkg::ST_RUNNING;
            end
            csl_pkg::ST_HALT: begin
                if (cmd_reset || cmd_dnld)
                    state_d = csl_pkg::ST_STOP_ENTRY;
            end
            default: state_d = csl_pkg::ST_EMPTY;
        endcase
        if (sys_error_evt)
            state_d = csl_pkg::ST_EMPTY_SYSERR;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_q     <= csl_pkg::ST_EMPTY;
            boot_seen_q <= 1'b0;
        end else begin
            state_q     <= state_d;
            boot_seen_q <= 1'b1;
        end
    end

    wire            is_run     = state_q == csl_pkg::ST_RUNNING;
    wire            is_entry   = state_q == csl_pkg::ST_STOP_ENTRY;
    wire            is_stop    = state_q == csl_pkg::ST_STOPPED;
    wire            is_halt    = state_q == csl_pkg::ST_HALT;
    wire            has_app    = is_run | is_entry | is_stop;
    wire            io_fault   = ext_io_error | (|system_fault_word_a) | (|system_fault_word_b);

    // indicator selection
    wire            run_led_w  = is_run ? (breakpoint_active ? sgl_fl : 1'b1) :
                                 (is_entry | is_stop | is_halt) ? reg_fl : 1'b0;
    wire            err_led_w  = (state_q == csl_pkg::ST_EMPTY)        ? sgl_fl :
                                 (state_q == csl_pkg::ST_EMPTY_SYSERR) ? fast_fl :
                                 is_halt                               ? 1'b1 :
                                 (has_app & boot_differs)              ? sgl_fl :
                                 1'b0;
    // halt leaves the io indicator free; it keeps showing faults there
    wire            io_led_w   = (has_app | is_halt) & io_fault;

    // stopped never runs tasks; a breakpoint suspends them while running
    wire            task_w     = is_run & ~breakpoint_active;
    // sampling goes on through the apply cycle and stops after it when not updating
    wire            sample_w   = is_run | is_entry | (is_stop & upd_w);
    wire            can_w      = is_run | is_entry | (is_stop & upd_w);

    wire [W-1:0]    stop_src   = dflt_w ? out_dflt : phys_out_q;
    wire [W-1:0]    run_out    = (out_img & ~force_mask) | (force_val & force_mask);
    wire [W-1:0]    entry_out  = (stop_src & ~force_mask) | (force_val & force_mask);
    wire [W-1:0]    upd_out    = (stop_val_q & ~force_mask) | (force_val & force_mask);
    // without update the remote image may change but the pins stay put
    wire [W-1:0]    phys_d     = is_run   ? run_out :
                                 is_entry ? entry_out :
                                 (is_stop & upd_w) ? upd_out :
                                 (is_stop | is_halt) ? phys_out_q :
                                 {W{1'b0}};

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            in_img_q   <= {W{1'b0}};
            phys_out_q <= {W{1'b0}};
            stop_val_q <= {W{1'b0}};
        end else begin
            if (sample_w)
                in_img_q <= phys_in;
            phys_out_q <= phys_d;
            if (is_entry)
                stop_val_q <= stop_src;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            led_run_q    <= 1'b0;
            led_err_q    <= 1'b0;
            led_io_q     <= 1'b0;
            task_en_q    <= 1'b0;
            can_active_q <= 1'b0;
            tpdo_load_q  <= 1'b0;
            tpdo_dflt_q  <= 1'b0;
            tpdo_send_q  <= 1'b0;
        end else begin
            led_run_q    <= run_led_w;
            led_err_q    <= err_led_w;
            led_io_q     <= io_led_w;
            task_en_q    <= task_w;
            can_active_q <= can_w;
            // tpdos take current or default values on entry; defaults persist
            tpdo_load_q  <= is_entry;
            tpdo_dflt_q  <= (is_entry | is_stop) & dflt_w;
            // the single send happens only when the master is about to go quiet
            tpdo_send_q  <= is_entry & ~upd_w;
        end
    end

    assign prdata     = prdata_q;
    assign pready     = pready_q;
    assign pslverr    = pslverr_q;
    assign in_img     = in_img_q;
    assign phys_out   = phys_out_q;
    assign led_run    = led_run_q;
    assign led_err    = led_err_q;
    assign led_io     = led_io_q;
    assign task_en    = task_en_q;
    assign can_active = can_active_q;
    assign tpdo_load  = tpdo_load_q;
    assign tpdo_dflt  = tpdo_dflt_q;
    assign tpdo_send  = tpdo_send_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence seq_stop_req;
        is_run && cmd_stop && !app_error_evt && !sys_error_evt;
    endsequence

    sequence seq_stop_walk;
        is_entry ##1 (is_stop || state_q == csl_pkg::ST_EMPTY_SYSERR);
    endsequence

    chk_empty_leds: assert property ((nrst && state_q == csl_pkg::ST_EMPTY) |=>
        !led_run_q && !led_io_q && led_err_q == $past(sgl_fl))
        else $error("empty state indicators wrong");

    chk_syserr_entry: assert property (sys_error_evt |=>
        state_q == csl_pkg::ST_EMPTY_SYSERR ##1 led_err_q == $past(fast_fl))
        else $error("system error not taken or err not fast");

    chk_run_leds: assert property ((is_run && !breakpoint_active && !io_fault
        && !boot_differs) |=> led_run_q && !led_err_q && !led_io_q)
        else $error("running indicators wrong");

    chk_bp_suspend: assert property ((is_run && breakpoint_active) |=>
        !task_en_q && led_run_q == $past(sgl_fl))
        else $error("breakpoint did not suspend tasks");

    chk_fault_io: assert property ((is_run && (|system_fault_word_b)) |=> led_io_q)
        else $error("fault word did not light io");

    chk_stop_notask: assert property (is_stop |=> !task_en_q &&
        led_err_q == ($past(boot_differs) && $past(sgl_fl)))
        else $error("task enabled while stopped");

    chk_stop_entry: assert property (seq_stop_req |=> seq_stop_walk)
        else $error("stop request did not pass the apply step");

    chk_send_once: assert property ((is_entry && !upd_w && !sys_error_evt) |=>
        tpdo_send_q && tpdo_load_q ##1 !tpdo_send_q)
        else $error("tpdo not sent exactly once");

    chk_in_freeze: assert property ((is_stop && !upd_w) |=> $stable(in_img_q))
        else $error("inputs sampled while frozen");

    chk_can_quiet: assert property ((is_stop && !upd_w) |=> !can_active_q)
        else $error("can master active with update off");

    chk_can_upd: assert property ((is_stop && upd_w) |=> can_active_q)
        else $error("can master stopped with update on");

    chk_phys_hold: assert property ((is_stop && !upd_w) |=> $stable(phys_out_q))
        else $error("physical outputs moved with update off");

    chk_halt_stay: assert property ((is_halt && !cmd_reset && !cmd_dnld
        && !sys_error_evt) |=> is_halt)
        else $error("halt left without reset or download");

    chk_stop_leds: assert property (is_stop |=>
        led_run_q == $past(reg_fl) && led_io_q == $past(io_fault))
        else $error("stopped indicators wrong");

    chk_in_sample: assert property ((is_stop && upd_w) |=>
        in_img_q == $past(phys_in))
        else $error("inputs not sampled while updating");

    chk_upd_image: assert property ((is_stop && upd_w) |=>
        ((phys_out_q ^ $past(force_val)) & $past(force_mask)) == {W{1'b0}} &&
        ((phys_out_q ^ $past(stop_val_q)) & ~$past(force_mask)) == {W{1'b0}})
        else $error("stopped image not written with forcing");

    chk_entry_apply: assert property (is_entry |=>
        ((phys_out_q ^ $past(force_val)) & $past(force_mask)) == {W{1'b0}} &&
        (!$past(dflt_w) || ((phys_out_q ^ $past(out_dflt)) & ~$past(force_mask)) == {W{1'b0}}))
        else $error("stop behaviour not applied on entry");

    chk_tpdo_dflt: assert property (is_entry |=>
        tpdo_load_q && tpdo_dflt_q == $past(dflt_w))
        else $error("tpdo value kind wrong on entry");

    chk_halt_leds: assert property (is_halt |=>
        led_err_q && !task_en_q && !can_active_q && led_run_q == $past(reg_fl))
        else $error("halt indicators or task gating wrong");

    chk_phase_wrap: assert property ((tick_w && phase_end) |=> phase_q == 5'h00)
        else $error("flash phase did not wrap");

    chk_err_boot: assert property ((has_app && boot_differs) |=>
        led_err_q == $past(sgl_fl))
        else $error("boot copy difference not flashed");

endmodule : csl_top

// [verification/csl_can_node.sv]
// Purpose: far-side can node model that counts tpdo traffic from the master
// Assumes: load and send pulses last one clk_sys cycle
// Notes:   keeps the value kind of the last loaded tpdo set
`timescale 1ns/1ps

module csl_can_node (
    input  wire logic clk_sys,
    input  wire logic nrst,
    input  wire logic tpdo_load,
    input  wire logic tpdo_dflt,
    input  wire logic tpdo_send,
    output int        n_send,
    output logic      last_dflt
);
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            n_send    <= 0;
            last_dflt <= 1'b0;
        end else begin
            n_send <= n_send + int'(tpdo_send);
            if (tpdo_load) begin
                last_dflt <= tpdo_dflt;
            end
        end
    end
endmodule : csl_can_node

// [verification/csl_tb_top.sv]
// Purpose: self-checking bench for the controller state supervisor
// Assumes: tick shortened to 2 cycles; apb answer awaited under the global timeout
// Notes:   flash patterns judged by lit cycles and rising edges over whole periods
`timescale 1ns/1ps
`include "csl_defs.svh"

module controller_state_led_io_control_tb_top;
    localparam int TK = 2;
    localparam int ON_T [5] = '{0, 48 * TK, 24 * TK, 8 * TK, 24 * TK};
    localparam int RISE_T [5] = '{0, 0, 6, 2, 24};
    localparam int OFF = 0, ON = 1, REG = 2, SGL = 3, FST = 4, ANY = 5;
    logic        clk_sys, nrst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, system_fault_word_a, system_fault_word_b;
    logic [3:0]  pstrb;
    logic        app_present, sys_error_evt, app_error_evt, ext_io_error;
    logic        breakpoint_active, boot_differs, led_run, led_err, led_io;
    logic        task_en, can_active, tpdo_load, tpdo_dflt, tpdo_send, last_dflt;
    logic [15:0] phys_in, out_img, out_dflt, force_mask, force_val, in_img, phys_out;
    logic [2:0]  leds;
    int          n_fail, check_count, cyc, n_send, n0;

    assign leds = {led_io, led_err, led_run};

    csl_top #(.W(16), .TICK_CYC(TK)) i_csl_top (
        .clk_sys, .nrst, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata,
        .pready, .pslverr, .app_present, .sys_error_evt, .app_error_evt, .ext_io_error,
        .breakpoint_active, .boot_differs, .system_fault_word_a, .system_fault_word_b,
        .phys_in, .out_img, .out_dflt, .force_mask, .force_val, .in_img, .phys_out,
        .led_run, .led_err, .led_io, .task_en, .can_active, .tpdo_load, .tpdo_dflt,
        .tpdo_send
    );
    csl_can_node i_csl_can_node (
        .clk_sys, .nrst, .tpdo_load, .tpdo_dflt, .tpdo_send, .n_send, .last_dflt
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        repeat (8) @(posedge clk_sys);
    endtask : wr

    task automatic cmd(input int b);
        wr(`CSL_REG_CMD, 32'h0000_0001 << b);
    endtask : cmd

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk(r, exp);
        chk({31'h0000_0000, e}, {31'h0000_0000, exp_err});
    endtask : rd

    task automatic st(input csl_pkg::csl_state_type s);
        logic [31:0] r;
        logic        e;
        apb(1'b0, `CSL_REG_STATUS, 32'h0000_0000, r, e);
        chk({29'h0000_0000, r[2:0]}, {29'h0000_0000, s});
    endtask : st

    // 48-tick windows of two whole 24-tick periods make the counts independent of the flash phase
    task automatic led(input int k, input int pat);
        int   on, rise;
        logic p;
        if (pat == ANY) return;
        on = 0;
        rise = 0;
        @(posedge clk_sys);
        p = leds[k];
        repeat (48 * TK) begin
            @(posedge clk_sys);
            on += int'(leds[k] === 1'b1);
            rise += int'(leds[k] === 1'b1 && p !== 1'b1);
            p = leds[k];
        end
        chk(32'(on), 32'(ON_T[pat]));
        chk(32'(rise), 32'(RISE_T[pat]));
    endtask : led

    task automatic pats(input int r, input int e, input int i);
        repeat (8) @(posedge clk_sys);
        led(0, r);
        led(1, e);
        led(2, i);
    endtask : pats

    task automatic t_empty_and_regs;
        st(csl_pkg::ST_EMPTY);
        pats(OFF, SGL, OFF);
        pstrb <= 4'h0;
        wr(`CSL_REG_CTRL, 32'h0000_0000);
        pstrb <= 4'hF;
        rd(`CSL_REG_CTRL, 32'h0000_0001, 1'b0);
        rd(12'h014, 32'h0000_0000, 1'b1);
        @(posedge clk_sys);
        system_fault_word_a <= 32'h8000_0001;
        rd(`CSL_REG_FAULT_A, 32'h8000_0001, 1'b0);
        system_fault_word_a <= 32'h0000_0000;
    endtask : t_empty_and_regs

    task automatic t_sys_error;
        @(posedge clk_sys);
        sys_error_evt <= 1'b1;
        @(posedge clk_sys);
        sys_error_evt <= 1'b0;
        st(csl_pkg::ST_EMPTY_SYSERR);
        pats(OFF, FST, OFF);
        cmd(`CSL_CMD_DNLD);
        st(csl_pkg::ST_STOPPED);
    endtask : t_sys_error

    task automatic t_stopped_leds;
        pats(REG, OFF, OFF);
        chk(32'(task_en), 32'h0000_0000);
        ext_io_error <= 1'b1;
        pats(REG, OFF, ON);
        ext_io_error <= 1'b0;
    endtask : t_stopped_leds

    task automatic t_running;
        cmd(`CSL_CMD_RUN);
        st(csl_pkg::ST_RUNNING);
        pats(ON, OFF, OFF);
        chk({task_en, can_active, phys_out}, {2'b11, 16'h12A5});
        system_fault_word_b <= 32'h0000_0100;
        pats(ON, OFF, ON);
        system_fault_word_b <= 32'h0000_0000;
        boot_differs <= 1'b1;
        pats(ON, SGL, OFF);
        boot_differs <= 1'b0;
        breakpoint_active <= 1'b1;
        pats(SGL, OFF, OFF);
        chk(32'(task_en), 32'h0000_0000);
        breakpoint_active <= 1'b0;
    endtask : t_running

    task automatic t_stop_update_on;
        n0 = n_send;
        cmd(`CSL_CMD_STOP);
        chk(32'(n_send - n0), 32'h0000_0000);
        chk({task_en, can_active, last_dflt, phys_out}, {3'b010, 16'h12A5});
        phys_in <= 16'h3C3C;
        force_mask <= 16'hF000;
        force_val <= 16'h5000;
        out_img <= 16'hBEEF;
        repeat (8) @(posedge clk_sys);
        chk({in_img, phys_out}, {16'h3C3C, 16'h52A5});
        force_mask <= 16'h00FF;
        force_val <= 16'h00A5;
        out_img <= 16'h1234;
    endtask : t_stop_update_on

    task automatic t_stop_update_off;
        wr(`CSL_REG_CTRL, 32'h0000_0000);
        cmd(`CSL_CMD_RUN);
        phys_in <= 16'h1111;
        n0 = n_send;
        cmd(`CSL_CMD_STOP);
        chk(32'(n_send - n0), 32'h0000_0001);
        chk({can_active, phys_out}, {1'b0, 16'h12A5});
        phys_in <= 16'h2222;
        force_mask <= 16'hF000;
        force_val <= 16'h5000;
        repeat (20) @(posedge clk_sys);
        chk({in_img, phys_out}, {16'h1111, 16'h12A5});
        chk(32'(n_send - n0), 32'h0000_0001);
        force_mask <= 16'h00FF;
        force_val <= 16'h00A5;
    endtask : t_stop_update_off

    task automatic t_stop_default;
        wr(`CSL_REG_CTRL, 32'h0000_0003);
        cmd(`CSL_CMD_RUN);
        cmd(`CSL_CMD_STOP);
        chk({can_active, tpdo_dflt, last_dflt, phys_out}, {3'b111, 16'h0FA5});
    endtask : t_stop_default

    task automatic t_halt;
        logic [31:0] r;
        logic        e;
        cmd(`CSL_CMD_RUN);
        app_error_evt <= 1'b1;
        @(posedge clk_sys);
        app_error_evt <= 1'b0;
        st(csl_pkg::ST_HALT);
        pats(REG, ON, ANY);
        chk(32'(task_en), 32'h0000_0000);
        cmd(`CSL_CMD_RUN);
        st(csl_pkg::ST_HALT);
        cmd(`CSL_CMD_STOP);
        st(csl_pkg::ST_HALT);
        cmd(`CSL_CMD_RESET);
        apb(1'b0, `CSL_REG_STATUS, 32'h0000_0000, r, e);
        chk(32'(r[2:0] === csl_pkg::ST_HALT), 32'h0000_0000);
        cmd(`CSL_CMD_DNLD);
        st(csl_pkg::ST_STOPPED);
    endtask : t_halt

    // power cycle with a stored application: straight to stopped, outputs applied
    task automatic t_reboot;
        @(posedge clk_sys);
        app_present <= 1'b1;
        nrst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (4) @(posedge clk_sys);
        st(csl_pkg::ST_STOPPED);
        chk({in_img, phys_out}, {16'h2222, 16'h00A5});
        chk(32'(can_active), 32'h0000_0001);
        app_present <= 1'b0;
    endtask : t_reboot

    task automatic tally_and_finish;
        if (n_fail == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    initial begin
        {nrst, psel, penable, pwrite, app_present, sys_error_evt, app_error_evt} = '0;
        {ext_io_error, breakpoint_active, boot_differs} = '0;
        {paddr, pwdata, system_fault_word_a, system_fault_word_b, phys_in} = '0;
        pstrb = 4'hF;
        out_img = 16'h1234;
        out_dflt = 16'h0F0F;
        force_mask = 16'h00FF;
        force_val = 16'h00A5;
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        t_empty_and_regs();
        t_sys_error();
        t_stopped_leds();
        t_running();
        t_stop_update_on();
        t_stop_update_off();
        t_stop_default();
        t_halt();
        t_reboot();
        tally_and_finish();
    end
endmodule : controller_state_led_io_control_tb_top
